// ---- sbdcr_defs.svh ----
/*
 * Constants of the processor fabric: address map, APB slot layout, SPI timing and register map.
 * Assumes it is included by bare name from the package only; the design modules get its macros from there.
 */
`ifndef SBDCR_DEFS_SVH
`define SBDCR_DEFS_SVH

// Processor address map
`define SBDCR_MEM_BASE      32'h8000_0000
`define SBDCR_MEM_LAST      32'h8FFF_FFFC
`define SBDCR_IO_BASE       32'h6000_0000
`define SBDCR_IO_LAST       32'h7FFF_FFFF
// Program RAM: 64 K words of 32 bits
`define SBDCR_RAM_AW        16
`define SBDCR_RAM_MSB       17
`define SBDCR_RAM_LSB       2
// APB: 16 address bits, slot number in paddr[15:12]
`define SBDCR_PADDR_W       16
`define SBDCR_SLOT_MSB      15
`define SBDCR_SLOT_LSB      12
`define SBDCR_SLOT_MAC      4'h0
`define SBDCR_SLOT_UART     4'h1
`define SBDCR_SLOT_SPI      4'h2
// System clock figures
`define SBDCR_OSC_MHZ       50
`define SBDCR_SYS_MHZ       80
// SPI master: sclk = sysclk / (2 * (rate + 1))
`define SBDCR_SPI_RATE      4'h7
`define SBDCR_SPI_HALF_END  (`SBDCR_SPI_RATE)
`define SBDCR_SPI_LAST_BIT  4'hF
`define SBDCR_FIFO_DEPTH    6'h20
`define SBDCR_FIFO_AW       5
// SPI registers, offsets inside the slot
`define SBDCR_SPI_DATA_OFS  12'h000
`define SBDCR_SPI_STAT_OFS  12'h004
// Status bit positions
`define SBDCR_ST_TXFULL     0
`define SBDCR_ST_TXEMPTY    1
`define SBDCR_ST_RXFULL     2
`define SBDCR_ST_RXEMPTY    3
`define SBDCR_ST_BUSY       4
`define SBDCR_ST_RXOVF      5

`endif

// ---- sbdcr_pkg.sv ----
/*
 * Types of the processor fabric: state enumerations and the packed state records.
 * Assumes sbdcr_defs.svh is on the include path.
 */
package sbdcr_pkg;
    `include "sbdcr_defs.svh"

    typedef enum logic [2:0] {BUS_IDLE, BUS_MEM, BUS_WDATA, BUS_SETUP, BUS_ACCESS, BUS_ERR} sbdcr_bus_st_type;
    typedef enum logic {SPI_IDLE, SPI_SHIFT} sbdcr_spi_st_type;

    typedef struct packed {
        logic [1:0]       init_sync;
        logic [1:0]       lock_sync;
        logic [1:0]       link_sync;
        logic             user_rstn;
        logic             link_ok;
        sbdcr_bus_st_type st;
        logic [31:0]      addr;
        logic             wr;
        logic             hready;
        logic             hresp;
        logic [31:0]      hrdata;
        logic [2:0]       psel;
        logic             penable;
        logic             pwrite;
        logic [15:0]      paddr;
        logic [31:0]      pwdata;
    } sbdcr_top_type;

    typedef struct packed {
        sbdcr_spi_st_type st;
        logic [3:0]       div;
        logic [3:0]       bitcnt;
        logic [15:0]      shreg;
        logic [15:0]      rxsh;
        logic             sclk;
        logic             ssel_n;
        logic [1:0]       miso_sync;
        logic [5:0]       tx_wr;
        logic [5:0]       tx_rd;
        logic [5:0]       rx_wr;
        logic [5:0]       rx_rd;
        logic             rx_ovf;
    } sbdcr_spi_type;
endpackage : sbdcr_pkg

// ---- sbdcr_spi.sv ----
/*
 * SPI master on APB slot 2: 16-bit frames, mode 0, 32-deep transmit and receive queues.
 * Assumes an asynchronous active-low reset released on mclk_i and an APB master on the same clock that never
 * needs wait states from this slot.
 */
`timescale 1ns/1ps
module sbdcr_spi
    import sbdcr_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_ni,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    input  wire logic        spi_miso_i,
    output logic             spi_sclk_o,
    output logic             spi_mosi_o,
    output logic             spi_ssel_n_o
);
    import sbdcr_pkg::*;

    sbdcr_spi_type r, nxt;
    logic [15:0] txmem [0:31];
    logic [15:0] rxmem [0:31];
    logic [5:0]  tx_cnt, rx_cnt;
    logic        tx_full, tx_empty, rx_full, rx_empty;
    logic        tx_push, tx_pop, rx_push, rx_pop, data_hit, stat_hit, fr_done;
    logic [5:0]  status;

    // Queue levels; pointers carry one extra bit so full and empty differ
    assign tx_cnt   = r.tx_wr - r.tx_rd;
    assign rx_cnt   = r.rx_wr - r.rx_rd;
    assign tx_full  = (tx_cnt == `SBDCR_FIFO_DEPTH);
    assign rx_full  = (rx_cnt == `SBDCR_FIFO_DEPTH);
    assign tx_empty = (tx_cnt == 6'h00);
    assign rx_empty = (rx_cnt == 6'h00);
    assign data_hit = (paddr_i == `SBDCR_SPI_DATA_OFS);
    assign stat_hit = (paddr_i == `SBDCR_SPI_STAT_OFS);
    assign status   = {r.rx_ovf, (r.st == SPI_SHIFT), rx_empty, rx_full, tx_empty, tx_full};

    // Read data: data register pops the receive queue, status shows the engine
    always_comb begin
        prdata_o = 32'h0000_0000;
        if (data_hit) begin
            prdata_o = {16'h0000, rxmem[r.rx_rd[4:0]]};
        end else if (stat_hit) begin
            prdata_o = {26'h000_0000, status};
        end
    end

    // Engine and queue control
    always_comb begin
        nxt     = r;
        tx_pop  = 1'b0;
        rx_push = 1'b0;
        fr_done = 1'b0;
        tx_push = psel_i && penable_i && pwrite_i && data_hit && !tx_full;    // RULE_10
        rx_pop  = psel_i && penable_i && !pwrite_i && data_hit && !rx_empty;
        nxt.miso_sync = {r.miso_sync[0], spi_miso_i};
        unique case (r.st)
            SPI_IDLE: begin
                nxt.sclk   = 1'b0;                                            // RULE_09
                nxt.ssel_n = 1'b1;
                if (!tx_empty) begin
                    tx_pop     = 1'b1;
                    nxt.shreg  = txmem[r.tx_rd[4:0]];
                    nxt.ssel_n = 1'b0;
                    nxt.bitcnt = 4'h0;
                    nxt.div    = 4'h0;
                    nxt.st     = SPI_SHIFT;
                end
            end
            SPI_SHIFT: begin
                // Each half period lasts rate + 1 system clocks
                nxt.div = (r.div == `SBDCR_SPI_HALF_END) ? 4'h0 : r.div + 4'h1;  // RULE_08
                if (r.div == `SBDCR_SPI_HALF_END) begin
                    if (!r.sclk) begin
                        nxt.sclk = 1'b1;
                        nxt.rxsh = {r.rxsh[14:0], r.miso_sync[1]};            // RULE_09
                    end else begin
                        nxt.sclk = 1'b0;
                        if (r.bitcnt == `SBDCR_SPI_LAST_BIT) begin
                            fr_done = 1'b1;
                            rx_push = !rx_full;
                            nxt.rx_ovf = r.rx_ovf | rx_full;
                            // Queued frame follows with select held low
                            if (!tx_empty) begin
                                tx_pop     = 1'b1;                            // RULE_11
                                nxt.shreg  = txmem[r.tx_rd[4:0]];
                                nxt.bitcnt = 4'h0;
                            end else begin
                                nxt.ssel_n = 1'b1;
                                nxt.st     = SPI_IDLE;
                            end
                        end else begin
                            nxt.shreg  = {r.shreg[14:0], 1'b0};
                            nxt.bitcnt = r.bitcnt + 4'h1;
                        end
                    end
                end
            end
        endcase
        // Write one to clear overflow; a new overflow in the same cycle wins
        if (psel_i && penable_i && pwrite_i && stat_hit && pwdata_i[`SBDCR_ST_RXOVF] && !(fr_done && rx_full)) begin
            nxt.rx_ovf = 1'b0;
        end
        if (tx_push) nxt.tx_wr = r.tx_wr + 6'h01;
        if (tx_pop)  nxt.tx_rd = r.tx_rd + 6'h01;
        if (rx_push) nxt.rx_wr = r.rx_wr + 6'h01;
        if (rx_pop)  nxt.rx_rd = r.rx_rd + 6'h01;
    end

    // Queue storage, no reset needed
    always_ff @(posedge mclk_i) begin
        if (tx_push) txmem[r.tx_wr[4:0]] <= pwdata_i[15:0];
        if (rx_push) rxmem[r.rx_wr[4:0]] <= r.rxsh;
    end

    always_ff @(posedge mclk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            r        <= '0;
            r.ssel_n <= 1'b1;
        end else begin
            r <= nxt;
        end
    end

    assign spi_sclk_o   = r.sclk;
    assign spi_mosi_o   = r.shreg[15];
    assign spi_ssel_n_o = r.ssel_n;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_ni);

    property p_sclk_half;
        $rose(r.sclk) |-> r.sclk [*8] ##1 !r.sclk;
    endproperty
    a_sclk_half: assert property (p_sclk_half) else $error("sclk high phase not 8 clocks"); // RULE_08

    property p_mode0_idle;
        r.ssel_n |-> !r.sclk;
    endproperty
    a_mode0_idle: assert property (p_mode0_idle) else $error("sclk not low while deselected"); // RULE_09

    property p_frame_bits;
        (r.st == SPI_IDLE) && !tx_empty |=> (r.bitcnt == 4'h0) ##[255:256] fr_done;
    endproperty
    a_frame_bits: assert property (p_frame_bits) else $error("frame not 16 sclk periods"); // RULE_09

    property p_fifo_bound;
        (tx_cnt <= `SBDCR_FIFO_DEPTH) && (rx_cnt <= `SBDCR_FIFO_DEPTH) && !(tx_full && tx_push);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("queue level beyond 32"); // RULE_10

    property p_keep_sel;
        fr_done && !tx_empty |=> !r.ssel_n && (r.st == SPI_SHIFT);
    endproperty
    a_keep_sel: assert property (p_keep_sel) else $error("select released between frames"); // RULE_11

    c_back_to_back: cover property (fr_done && !tx_empty);
    c_tx_full: cover property (tx_full);
endmodule : sbdcr_spi

// ---- sbdcr_top.sv ----
/*
 * Processor fabric top: AHB-Lite address split, program RAM, APB slot decode with the
 * SPI master, reset gating and link-status output.
 * Assumes the processor drives AHB-Lite on mclk_i (the generated system clock) and that
 * init_done_i, pll_lock_i and autoneg_state_i are asynchronous to it.
 */
// Summary of operation
// RULE_01: 0x8000_0000..0x8FFF_FFFC goes to memory side
// RULE_02: 0x6000_0000..0x7FFF_FFFF goes to I/O side
// RULE_03: Processor boots from RAM at 0x8000_0000
// RULE_04: Program RAM holds 64 K words
// RULE_05: APB uses 16 bits, slots 0x0000/0x1000/0x2000
// RULE_06: Three slots: MAC, UART, SPI master
// RULE_07: APB carries 32-bit read and write data
// RULE_08: SPI clock is sysclk over 2*(7+1)
// RULE_09: SPI frames are 16 bits, mode 0
// RULE_10: SPI queues hold 32 frames each
// RULE_11: SPI select held across back-to-back frames
// RULE_12: Single 80 MHz system clock drives everything
// RULE_13: User reset needs init done and lock
// RULE_14: Reset release synchronised to the clock
// RULE_15: Link LED follows autonegotiation state
// RULE_16: Unmapped or unused-slot accesses get error
`timescale 1ns/1ps
module sbdcr_top
    import sbdcr_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    input  wire logic        init_done_i,
    input  wire logic        pll_lock_i,
    input  wire logic        autoneg_state_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic        hwrite_i,
    input  wire logic [31:0] hwdata_i,
    output logic      [31:0] hrdata_o,
    output logic             hready_o,
    output logic             hresp_o,
    output logic [15:0]      paddr_o,
    output logic [1:0]       psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic [31:0]      pwdata_o,
    input  wire logic [31:0] prdata_mac_i,
    input  wire logic [31:0] prdata_uart_i,
    input  wire logic [1:0]  pready_i,
    input  wire logic [1:0]  pslverr_i,
    input  wire logic        spi_miso_i,
    output logic             spi_sclk_o,
    output logic             spi_mosi_o,
    output logic             spi_ssel_n_o,
    output logic             user_resetn_o,
    output logic             link_ok_o
);
    import sbdcr_pkg::*;

    sbdcr_top_type r, nxt;
    logic [1:0]    rst_sync_ff;
    logic          rst_n;
    logic [31:0]   ram [0:(1 << `SBDCR_RAM_AW) - 1];
    logic [31:0]   prdata_spi;
    logic          acc, in_mem, in_io, slot_ok;
    logic          sel_ready, sel_err;
    logic [31:0]   sel_rdata;
    logic [3:0]    req_slot;

    // Reset release passes two flops so every block leaves reset on a clean edge
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};                            // RULE_14
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Address phase decode on the live AHB request
    assign acc      = (r.st == BUS_IDLE) && htrans_i[1];
    assign in_mem   = (haddr_i >= `SBDCR_MEM_BASE) && (haddr_i <= `SBDCR_MEM_LAST);  // RULE_01
    assign in_io    = (haddr_i >= `SBDCR_IO_BASE) && (haddr_i <= `SBDCR_IO_LAST);    // RULE_02
    assign req_slot = haddr_i[`SBDCR_SLOT_MSB:`SBDCR_SLOT_LSB];
    assign slot_ok  = (req_slot == `SBDCR_SLOT_MAC) || (req_slot == `SBDCR_SLOT_UART)
                   || (req_slot == `SBDCR_SLOT_SPI);                                 // RULE_06

    // Answer of the selected APB slot; the SPI slot never stalls
    always_comb begin
        sel_ready = 1'b0;
        sel_err   = 1'b0;
        sel_rdata = 32'h0000_0000;
        unique case (1'b1)
            r.psel[0]: begin
                sel_ready = pready_i[0];
                sel_err   = pslverr_i[0];
                sel_rdata = prdata_mac_i;
            end
            r.psel[1]: begin
                sel_ready = pready_i[1];
                sel_err   = pslverr_i[1];
                sel_rdata = prdata_uart_i;
            end
            r.psel[2]: begin
                sel_ready = 1'b1;
                sel_rdata = prdata_spi;
            end
            default: ;
        endcase
    end

    // Bus state machine, status synchronisers and reset gating
    always_comb begin
        nxt = r;
        // Pins from other domains: two flops before use
        nxt.init_sync = {r.init_sync[0], init_done_i};
        nxt.lock_sync = {r.lock_sync[0], pll_lock_i};
        nxt.link_sync = {r.link_sync[0], autoneg_state_i};
        // Registered AND so the user reset cannot glitch on the two inputs
        nxt.user_rstn = r.init_sync[1] & r.lock_sync[1];                       // RULE_13
        nxt.link_ok   = r.link_sync[1];                                        // RULE_15
        unique case (r.st)
            BUS_IDLE: begin
                nxt.hready = 1'b1;
                nxt.hresp  = 1'b0;
                if (acc) begin
                    nxt.addr   = haddr_i;
                    nxt.wr     = hwrite_i;
                    nxt.hready = 1'b0;
                    if (in_mem) begin
                        nxt.st = BUS_MEM;                                      // RULE_01
                    end else if (in_io && slot_ok) begin
                        nxt.st = BUS_WDATA;                                    // RULE_02
                    end else begin
                        nxt.hresp = 1'b1;                                      // RULE_16
                        nxt.st    = BUS_ERR;
                    end
                end
            end
            BUS_MEM: begin
                // RAM aliases through the region on the low 16 word bits
                if (!r.wr) begin
                    nxt.hrdata = ram[r.addr[`SBDCR_RAM_MSB:`SBDCR_RAM_LSB]];  // RULE_04
                end
                nxt.hready = 1'b1;
                nxt.st     = BUS_IDLE;
            end
            BUS_WDATA: begin
                // Write data is only valid in the AHB data phase, hence this extra cycle
                nxt.pwdata  = hwdata_i;                                        // RULE_07
                nxt.paddr   = r.addr[`SBDCR_PADDR_W-1:0];                      // RULE_05
                nxt.pwrite  = r.wr;
                nxt.psel    = 3'b001 << r.addr[`SBDCR_SLOT_LSB+1:`SBDCR_SLOT_LSB]; // RULE_06
                nxt.st      = BUS_SETUP;
            end
            BUS_SETUP: begin
                nxt.penable = 1'b1;
                nxt.st      = BUS_ACCESS;
            end
            BUS_ACCESS: begin
                if (sel_ready) begin
                    nxt.psel    = 3'b000;
                    nxt.penable = 1'b0;
                    if (!r.wr) begin
                        nxt.hrdata = sel_rdata;                                // RULE_07
                    end
                    if (sel_err) begin
                        nxt.hresp = 1'b1;
                        nxt.st    = BUS_ERR;
                    end else begin
                        nxt.hready = 1'b1;
                        nxt.st     = BUS_IDLE;
                    end
                end
            end
            BUS_ERR: begin
                // Second cycle of the two-cycle error answer
                nxt.hready = 1'b1;
                nxt.hresp  = 1'b1;
                nxt.st     = BUS_IDLE;
            end
        endcase
    end

    // Program RAM write port; contents survive reset
    always_ff @(posedge mclk_i) begin
        if ((r.st == BUS_MEM) && r.wr) begin
            ram[r.addr[`SBDCR_RAM_MSB:`SBDCR_RAM_LSB]] <= hwdata_i;           // RULE_04
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            r        <= '0;
            r.hready <= 1'b1;
        end else begin
            r <= nxt;
        end
    end

    // SPI master sits in slot 2
    sbdcr_spi u_spi (
        .mclk_i       (mclk_i),
        .rst_ni       (rst_n),
        .psel_i       (r.psel[2]),
        .penable_i    (r.penable),
        .pwrite_i     (r.pwrite),
        .paddr_i      (r.paddr[11:0]),
        .pwdata_i     (r.pwdata),
        .prdata_o     (prdata_spi),
        .spi_miso_i   (spi_miso_i),
        .spi_sclk_o   (spi_sclk_o),
        .spi_mosi_o   (spi_mosi_o),
        .spi_ssel_n_o (spi_ssel_n_o)
    );

    // Outputs come straight from the state record
    assign hrdata_o      = r.hrdata;
    assign hready_o      = r.hready;
    assign hresp_o       = r.hresp;
    assign paddr_o       = r.paddr;
    assign psel_o        = r.psel[1:0];
    assign penable_o     = r.penable;
    assign pwrite_o      = r.pwrite;
    assign pwdata_o      = r.pwdata;
    assign user_resetn_o = r.user_rstn;
    assign link_ok_o     = r.link_ok;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    property p_mem_route;
        acc && in_mem |=> !hready_o ##1 (hready_o && !hresp_o && (psel_o == 2'b00));
    endproperty
    a_mem_route: assert property (p_mem_route) else $error("memory access not answered in 2 cycles"); // RULE_01

    property p_io_route;
        acc && in_io && slot_ok |-> ##2 ((r.psel != 3'b000) && !penable_o) ##1 penable_o;
    endproperty
    a_io_route: assert property (p_io_route) else $error("I/O access did not reach APB"); // RULE_02

    property p_slot_addr;
        (r.psel != 3'b000) |-> (r.psel == (3'b001 << paddr_o[13:12])) && (paddr_o[15:14] == 2'b00);
    endproperty
    a_slot_addr: assert property (p_slot_addr) else $error("slot select disagrees with paddr"); // RULE_05

    property p_one_slot;
        $onehot0(r.psel);
    endproperty
    a_one_slot: assert property (p_one_slot) else $error("more than one APB slot selected"); // RULE_06

    property p_wdata_stable;
        penable_o |-> $stable(pwdata_o) && $stable(paddr_o);
    endproperty
    a_wdata_stable: assert property (p_wdata_stable) else $error("APB data moved in access phase"); // RULE_07

    property p_err_answer;
        acc && !in_mem && !(in_io && slot_ok) |=> (hresp_o && !hready_o) ##1 (hresp_o && hready_o);
    endproperty
    a_err_answer: assert property (p_err_answer) else $error("bad address lacks error answer"); // RULE_16

    property p_rst_gate;
        $rose(user_resetn_o) |-> $past(r.init_sync[1]) && $past(r.lock_sync[1]);
    endproperty
    a_rst_gate: assert property (p_rst_gate) else $error("user reset released without both inputs"); // RULE_13

    property p_link;
        link_ok_o == $past(autoneg_state_i, 3);
    endproperty
    a_link: assert property (p_link) else $error("link LED not 3 clocks behind state"); // RULE_15

    c_mem_read: cover property (acc && in_mem && !hwrite_i);
    c_apb_write: cover property (acc && in_io && slot_ok && hwrite_i);
    c_error: cover property (hresp_o && hready_o);
endmodule : sbdcr_top

// ---- sbdcr_ahb_master.sv ----
/* AHB-Lite master model standing in for the soft processor.
   Assumes registered hready/hresp from the fabric on the same clock. */
`timescale 1ns/1ps
module sbdcr_ahb_master (
    input  wire logic        mclk_i,
    input  wire logic        hready_i,
    input  wire logic        hresp_i,
    input  wire logic [31:0] hrdata_i,
    output logic      [1:0]  htrans_o,
    output logic      [31:0] haddr_o,
    output logic             hwrite_o,
    output logic      [31:0] hwdata_o
);
    initial {htrans_o, haddr_o, hwrite_o, hwdata_o} = '0;
    // One word; the address phase is offered once the fabric is ready, or after 64 clocks without it
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] rd, output logic rsp);
        int n;
        n = 0;
        @(negedge mclk_i);
        while (hready_i !== 1'b1 && n < 64) begin
            @(negedge mclk_i);
            n++;
        end
        htrans_o = 2'h2;
        haddr_o  = a;
        hwrite_o = w;
        @(negedge mclk_i);
        // Released address shows its inverse so a stale value cannot pass
        htrans_o = 2'h0;
        haddr_o  = ~a;
        hwdata_o = d;
        while (hready_i !== 1'b1 && n < 128) begin
            @(negedge mclk_i);
            n++;
        end
        rd  = hrdata_i;
        rsp = hresp_i;
    endtask : xfer
endmodule : sbdcr_ahb_master

// ---- sbdcr_top_bench.sv ----
/* Self-checking bench for the fabric top, random stimulus from a fixed seed.
   Assumes the master model of sbdcr_ahb_master.sv; inputs move on falling edges. */
`timescale 1ns/1ps
module sbdcr_top_bench;
    import sbdcr_pkg::*;
    logic        mclk_i = 0, resetn_i = 0, init_done_i = 0, pll_lock_i = 1;
    logic        autoneg_state_i = 0, spi_miso_i = 0, hwrite_i, rsp;
    logic [31:0] hrdata_o, pwdata_o, prdata_mac_i, prdata_uart_i, haddr_i, hwdata_i;
    logic [31:0] rnd = 32'd88316, mo = '0, cap_d, rd, d, a;
    logic [15:0] paddr_o, cap_a;
    logic [1:0]  htrans_i, psel_o, pready_i, pslverr_i;
    logic        hready_o, hresp_o, penable_o, pwrite_o, spi_sclk_o, spi_mosi_o;
    logic        spi_ssel_n_o, user_resetn_o, link_ok_o;
    int          err_count = 0, n_tests = 0, nrise = 0, nrel = 0, per = 0, cyc = 0, last = 0;
    logic [31:0] ta [8] = '{32'h8000_0000, 32'h8FFF_FFFC, 32'h6000_0004, 32'h7FFF_1008,
                            32'h9000_0000, 32'h5FFF_FFFC, 32'h6000_3000, 32'h8FFF_FFFD};
    sbdcr_top dut (.*);
    sbdcr_ahb_master host (.mclk_i(mclk_i), .hready_i(hready_o), .hresp_i(hresp_o),
        .hrdata_i(hrdata_o), .htrans_o(htrans_i), .haddr_o(haddr_i), .hwrite_o(hwrite_i),
        .hwdata_o(hwdata_i));
    always #10 mclk_i = ~mclk_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Expected error answer from the two decoded regions and three slots
    function automatic logic exp_err(input logic [31:0] a);
        return !((a >= 32'h8000_0000 && a <= 32'h8FFF_FFFC) || (a[31:29] == 3'h3 && a[15:12] < 4'h3));
    endfunction : exp_err
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    // Slots stall at random; miso loops mosi back, toggles while deselected
    always @(negedge mclk_i) begin
        rnd <= lfsr(rnd);
        pready_i <= rnd[1:0];
        spi_miso_i <= spi_ssel_n_o ? ~spi_miso_i : spi_mosi_o;
    end
    // Capture the completed APB access and the SPI wire activity
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (penable_o && (psel_o & pready_i) != 2'h0) begin
            cap_a <= paddr_o;
            cap_d <= pwdata_o;
        end
    end
    always @(posedge spi_sclk_o) begin
        mo = {mo[30:0], spi_mosi_o};
        nrise++;
        per = cyc - last;
        last = cyc;
    end
    always @(posedge spi_ssel_n_o) nrel++;
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_count++;
        print_verdict();
    end
    initial begin
        {prdata_mac_i, prdata_uart_i, pslverr_i} = '0;
        repeat (20) @(negedge mclk_i);
        resetn_i = 1;
        repeat (3) @(negedge mclk_i);
        chk("user reset held", user_resetn_o, 0);
        init_done_i = 1;
        repeat (2) @(negedge mclk_i);
        chk("user reset early", user_resetn_o, 0);
        @(negedge mclk_i);
        chk("user reset out", user_resetn_o, 1);
        pll_lock_i = 0;
        repeat (3) @(negedge mclk_i);
        chk("user reset lock", user_resetn_o, 0);
        pll_lock_i = 1;
        autoneg_state_i = 1;
        repeat (2) @(negedge mclk_i);
        chk("link early", link_ok_o, 0);
        @(negedge mclk_i);
        chk("link up", link_ok_o, 1);
        $display("reset and link test done");
        // Table corners first, then random words from 0x6000_0000 to 0x9FFF_DFFC (I/O, memory and unmapped)
        for (int i = 0; i < 16; i++) begin
            a = i < 8 ? ta[i] : {4'h6 + {2'h0, rnd[31:30]}, rnd[27:14], 1'b0, rnd[12:2], 2'h0};
            d = lfsr(rnd);
            prdata_mac_i = ~d;
            prdata_uart_i = {d[15:0], d[31:16]};
            host.xfer(a, 1'b1, d, rd, rsp);
            chk("write resp", rsp, exp_err(a));
            if (!exp_err(a) && !a[31]) begin
                chk("paddr", cap_a, a[15:0]);
                chk("pwdata", cap_d, d);
            end
            host.xfer(a, 1'b0, 32'h0, rd, rsp);
            chk("read resp", rsp, exp_err(a));
            if (!exp_err(a))
                chk("rdata", rd, a[31] ? d : a[12] ? prdata_uart_i : prdata_mac_i);
        end
        host.xfer(32'h8000_0000, 1'b1, d, rd, rsp);
        host.xfer(32'h8004_0000, 1'b0, 32'h0, rd, rsp);
        chk("ram alias", rd, d);
        pslverr_i = 2'h3;
        host.xfer(32'h6000_1000, 1'b0, 32'h0, rd, rsp);
        chk("slave error", rsp, 1);
        pslverr_i = 2'h0;
        $display("decode test done");
        // 33 frames back to back: queue fills, receive side overflows by one
        // Reset drives select high once, so the release counter starts afresh here
        nrise = 0;
        nrel = 0;
        d = rnd;
        for (int i = 0; i < 33; i++)
            host.xfer(32'h6000_2000, 1'b1, d ^ i, rd, rsp);
        host.xfer(32'h6000_2004, 1'b0, 32'h0, rd, rsp);
        chk("tx full", rd[0], 1);
        for (int n = 0; n < 9000 && nrel == 0; n++)
            @(negedge mclk_i);
        chk("sclk rises", nrise, 528);
        chk("sclk period", per, 16);
        chk("last frame", mo[15:0], d[15:0] ^ 16'h0020);
        host.xfer(32'h6000_2004, 1'b0, 32'h0, rd, rsp);
        chk("spi status", rd[5:0], 6'h26);
        host.xfer(32'h6000_2000, 1'b0, 32'h0, rd, rsp);
        chk("first rx", rd, {16'h0, d[15:0]});
        $display("spi test done");
        print_verdict();
    end
endmodule : sbdcr_top_bench
